/* File: logic/dcc_consts.svh */
// offsets, field positions, reset values and counts of the conversion controller
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH
// ==================================================
// register offsets (byte addresses)
`define DCC_OFF_CTRL_A 4'h0
`define DCC_OFF_CTRL_B 4'h1
`define DCC_OFF_EV_CTRL 4'h2
`define DCC_OFF_IEN_CLR 4'h4
`define DCC_OFF_IEN_SET 4'h5
`define DCC_OFF_IFLAGS 4'h6
`define DCC_OFF_STATUS 4'h7
`define DCC_OFF_CONV_LO 4'h8
`define DCC_OFF_CONV_HI 4'h9
`define DCC_OFF_STAGE_LO 4'hC
`define DCC_OFF_STAGE_HI 4'hD
// ==================================================
// field positions
`define DCC_A_SOFT_RESET_BIT 0
`define DCC_A_ENABLE 1
`define DCC_A_RUN_IN_STANDBY 2
`define DCC_B_EXT_OE 0
`define DCC_B_INT_OE 1
`define DCC_B_LEFT 2
`define DCC_B_PUMP_DIS 3
`define DCC_B_REFERENCE_SELECT 6
`define DCC_EV_START_EVENT_IN_ENABLE 0
`define DCC_EV_EMPTY_EVENT_OUT_ENABLE 1
`define DCC_EV_INV 4
`define DCC_IRQ_UNDERRUN 0
`define DCC_IRQ_EMPTY 1
`define DCC_IRQ_SYNC_READY_FLAG 2
`define DCC_STATUS_BUSY 7
// ==================================================
// reset values, codes and counts
`define DCC_BYTE_ZERO 8'h00
`define DCC_CODE_ZERO 10'h000
`define DCC_PAD_ZERO 6'h00
`define DCC_WORD_ZERO 16'h0000
`define DCC_IRQ_MASK 8'h07
`define DCC_REF_INTERNAL 2'h0
`define DCC_REF_SUPPLY 2'h1
`define DCC_REF_EXTERNAL 2'h2
`define DCC_REF_RESERVED 2'h3
`define DCC_SYNC_CYCLES 3
`endif

/* File: logic/dcc_pkg.sv */
// types shared by the conversion controller
package dcc_pkg;
   // ==================================================
   // synchronized operations in flight
   typedef enum logic [2:0] {
      DCC_OP_NONE,
      DCC_OP_SOFT_RESET_BIT,
      DCC_OP_ENABLE,
      DCC_OP_CONV,
      DCC_OP_STAGE
   } dcc_op_t;

   // byte-wide register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } dcc_reg_req_t;

   // analog-side controls
   typedef struct packed {
      logic ext_drive;
      logic int_route;
      logic pump_on;
      logic [1:0] ref_sel;
      logic ref_bad;
   } dcc_analog_t;
endpackage : dcc_pkg

/* File: logic/dcc_controller.sv */
// digital control of a single-channel 10-bit converter
// Behaviour
// [RULE1] writing enable one/zero enables/disables controller
// [RULE2] soft reset restores all registers, disables
// [RULE3] soft reset discards other bits written alongside
// [RULE4] pin driver on only while external enable
// [RULE5] reference select: internal, supply or external
// [RULE6] codes 0 internal,1 supply,2 external,3 reserved
// [RULE7] left-align bit positions code in both registers
// [RULE8] every conversion value load starts conversion; here a load starts one only while the controller is enabled
// [RULE9] loads from bus, DMA, or staging on event
// [RULE10] supplier spaces loads by conversion time
// [RULE11] empty flag and underrun flag
// [RULE12] request while flag and enable; set/clear enables
// [RULE13] enabled sources ORed into one request
// [RULE14] start event resynchronized, moves staging to value
// [RULE15] start action only when input enable set
// [RULE16] rising edge default, invert bit selects falling
// [RULE17] standby holds or disables buffer per run bit
// [RULE18] busy set at once, clears when synced
// [RULE19] synced write while busy discarded, error flagged
// [RULE20] reset, enable, value and staging writes synced
// [RULE21] internal route independent of external drive
// [RULE22] staging and value form two-entry FIFO
// [RULE23] empty event gated, empty flag always set
// [RULE24] pump automatic at low supply unless disabled
// [RULE25] converter clock at least four times sample rate
// [RULE26] underrun keeps value and starts nothing
`timescale 1ns/1ps
`include "dcc_consts.svh"

module dcc_controller #(
   parameter int NUM_EV = 1,
   parameter int SYNC_CYCLES = `DCC_SYNC_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire dcc_pkg::dcc_reg_req_t reg_req,
   output logic [7:0] reg_rdata_q,
   input wire logic dma_valid,
   input wire logic [15:0] dma_data,
   input wire logic [NUM_EV-1:0] start_ev,
   input wire logic standby,
   input wire logic supply_low,
   output logic [9:0] conv_code_q,
   output logic conv_start_q,
   output logic empty_event_q,
   output logic irq_q,
   output logic sync_error_q,
   output dcc_pkg::dcc_analog_t analog_q
);
   import dcc_pkg::*;

   // ==================================================
   // code alignment helpers
   function automatic logic [15:0] dcc_fmt(input logic left, input logic [9:0] code);
      dcc_fmt = left ? {code, `DCC_PAD_ZERO} : {`DCC_PAD_ZERO, code};
   endfunction : dcc_fmt

   function automatic logic [9:0] dcc_unfmt(input logic left, input logic [15:0] word);
      dcc_unfmt = left ? word[15:6] : word[9:0];
   endfunction : dcc_unfmt

   // ==================================================
   // state
   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] ev_ctrl_q;
   logic [7:0] ien_q;
   logic [7:0] iflags_q;
   logic [9:0] stage_code_q;
   logic stage_full_q;
   logic [7:0] conv_lo_q;
   logic [7:0] stage_lo_q;
   logic active_q;
   dcc_op_t op_q;
   logic [15:0] op_word_q;
   logic [7:0] sync_cnt_q;
   logic [NUM_EV-1:0] ev_s1_q;
   logic [NUM_EV-1:0] ev_s2_q;
   logic [NUM_EV-1:0] ev_s3_q;

   // ==================================================
   // decode of the register port
   wire wr_a = reg_req.wr && reg_req.addr == `DCC_OFF_CTRL_A;
   wire wr_b = reg_req.wr && reg_req.addr == `DCC_OFF_CTRL_B;
   wire wr_ev = reg_req.wr && reg_req.addr == `DCC_OFF_EV_CTRL;
   wire wr_iclr = reg_req.wr && reg_req.addr == `DCC_OFF_IEN_CLR;
   wire wr_iset = reg_req.wr && reg_req.addr == `DCC_OFF_IEN_SET;
   wire wr_flags = reg_req.wr && reg_req.addr == `DCC_OFF_IFLAGS;
   wire wr_conv_lo = reg_req.wr && reg_req.addr == `DCC_OFF_CONV_LO;
   wire wr_conv_hi = reg_req.wr && reg_req.addr == `DCC_OFF_CONV_HI;
   wire wr_stage_lo = reg_req.wr && reg_req.addr == `DCC_OFF_STAGE_LO;
   wire wr_stage_hi = reg_req.wr && reg_req.addr == `DCC_OFF_STAGE_HI;
   wire left = ctrl_b_q[`DCC_B_LEFT];
   wire busy = op_q != DCC_OP_NONE;

   // ==================================================
   // synchronized operation requests; soft reset beats every other bit
   wire req_soft_reset_bit = wr_a && reg_req.wdata[`DCC_A_SOFT_RESET_BIT]; // [RULE3]
   wire req_enable = wr_a && !reg_req.wdata[`DCC_A_SOFT_RESET_BIT];
   wire req_conv = wr_conv_hi || dma_valid; // [RULE9]
   wire req_stage = wr_stage_hi;
   wire req_any = req_soft_reset_bit || req_enable || req_conv || req_stage; // [RULE20]
   wire req_take = req_any && !busy;
   wire req_drop = req_any && busy; // [RULE19]
   wire [15:0] conv_word = wr_conv_hi ? {reg_req.wdata, conv_lo_q} : dma_data;
   wire dcc_op_t req_op = req_soft_reset_bit ? DCC_OP_SOFT_RESET_BIT :
                          req_enable ? DCC_OP_ENABLE :
                          req_conv ? DCC_OP_CONV : DCC_OP_STAGE;
   wire [15:0] req_word = req_stage ? {reg_req.wdata, stage_lo_q} : conv_word;

   // the op lands once the converter side has seen it
   wire op_done = busy && sync_cnt_q == 8'(SYNC_CYCLES - 1); // [RULE18]
   wire do_soft_reset_bit = op_done && op_q == DCC_OP_SOFT_RESET_BIT; // [RULE2]
   wire do_enable = op_done && op_q == DCC_OP_ENABLE;
   wire do_conv = op_done && op_q == DCC_OP_CONV; // [RULE8]
   wire do_stage = op_done && op_q == DCC_OP_STAGE;

   // ==================================================
   // start event edge detection, per-input polarity
   logic [NUM_EV-1:0] ev_edge;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_EV; gi++)
      begin : g_ev
         wire inv = ev_ctrl_q[`DCC_EV_INV + gi];
         // falling edge when inverted, rising otherwise
         assign ev_edge[gi] = inv ? (ev_s3_q[gi] && !ev_s2_q[gi]) :
                                    (ev_s2_q[gi] && !ev_s3_q[gi]); // [RULE16]
      end
   endgenerate

   // any connected input triggers the action, only when enabled
   wire start_hit = |ev_edge && ev_ctrl_q[`DCC_EV_START_EVENT_IN_ENABLE] && active_q; // [RULE15]
   wire move_stage = start_hit && stage_full_q; // [RULE14] [RULE22]
   wire underrun = start_hit && !stage_full_q; // [RULE26]
   wire went_empty = move_stage && !do_stage;

   // ==================================================
   // flags: hardware set wins over software clear
   wire [7:0] flag_set = {5'h00, do_soft_reset_bit ? 1'b0 : op_done,
                          went_empty, underrun}; // [RULE11] [RULE23]
   wire [7:0] flags_d = (iflags_q & ~(wr_flags ? reg_req.wdata : `DCC_BYTE_ZERO)
                         & `DCC_IRQ_MASK) | flag_set;
   wire [7:0] ien_d = (ien_q | (wr_iset ? reg_req.wdata : `DCC_BYTE_ZERO))
                      & ~(wr_iclr ? reg_req.wdata : `DCC_BYTE_ZERO)
                      & `DCC_IRQ_MASK; // [RULE12]

   // ==================================================
   // analog controls
   wire [1:0] reference_select = ctrl_b_q[`DCC_B_REFERENCE_SELECT +: 2];
   wire buf_on = !standby || ctrl_a_q[`DCC_A_RUN_IN_STANDBY]; // [RULE17]
   logic [1:0] ref_dec;
   always_comb
   begin
      // reserved code falls back to internal reference and is flagged
      case (reference_select)
         `DCC_REF_INTERNAL: ref_dec = `DCC_REF_INTERNAL;
         `DCC_REF_SUPPLY: ref_dec = `DCC_REF_SUPPLY;
         `DCC_REF_EXTERNAL: ref_dec = `DCC_REF_EXTERNAL;
         default: ref_dec = `DCC_REF_INTERNAL;
      endcase
   end
   wire dcc_analog_t analog_d = '{
      ext_drive: active_q && ctrl_b_q[`DCC_B_EXT_OE] && buf_on, // [RULE4]
      int_route: active_q && ctrl_b_q[`DCC_B_INT_OE], // [RULE21]
      pump_on: active_q && supply_low && !ctrl_b_q[`DCC_B_PUMP_DIS], // [RULE24]
      ref_sel: ref_dec, // [RULE5] [RULE6]
      ref_bad: reference_select == `DCC_REF_RESERVED
   };

   // ==================================================
   // read mux; unmapped offsets read zero
   wire [15:0] conv_rd = dcc_fmt(left, conv_code_q); // [RULE7]
   wire [15:0] stage_rd = dcc_fmt(left, stage_code_q);
   logic [7:0] rd_mux;
   always_comb
   begin
      case (reg_req.addr)
         `DCC_OFF_CTRL_A: rd_mux = ctrl_a_q;
         `DCC_OFF_CTRL_B: rd_mux = ctrl_b_q;
         `DCC_OFF_EV_CTRL: rd_mux = ev_ctrl_q;
         `DCC_OFF_IEN_CLR: rd_mux = ien_q;
         `DCC_OFF_IEN_SET: rd_mux = ien_q;
         `DCC_OFF_IFLAGS: rd_mux = iflags_q;
         `DCC_OFF_STATUS: rd_mux = {busy, 7'h00};
         `DCC_OFF_CONV_LO: rd_mux = conv_rd[7:0];
         `DCC_OFF_CONV_HI: rd_mux = conv_rd[15:8];
         `DCC_OFF_STAGE_LO: rd_mux = stage_rd[7:0];
         `DCC_OFF_STAGE_HI: rd_mux = stage_rd[15:8];
         default: rd_mux = `DCC_BYTE_ZERO;
      endcase
   end

   // ==================================================
   // event resynchronizer; first stage feeds only the second
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ev_s1_q <= '0;
         ev_s2_q <= '0;
         ev_s3_q <= '0;
      end
      else
      begin
         ev_s1_q <= start_ev; // [RULE14]
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
      end
   end

   // ==================================================
   // sync tracker: one op in flight, busy from the write onward
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         op_q <= DCC_OP_NONE;
         op_word_q <= `DCC_WORD_ZERO;
         sync_cnt_q <= 8'h00;
         sync_error_q <= 1'b0;
      end
      else
      begin
         sync_error_q <= req_drop; // [RULE19]
         if (req_take)
         begin
            op_q <= req_op; // [RULE18]
            op_word_q <= req_word;
            sync_cnt_q <= 8'h00;
         end
         else if (op_done)
            op_q <= DCC_OP_NONE;
         else if (busy)
            sync_cnt_q <= sync_cnt_q + 8'h01;
      end
   end

   // ==================================================
   // control registers; protected ones only move while disabled
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_a_q <= `DCC_BYTE_ZERO;
         ctrl_b_q <= `DCC_BYTE_ZERO;
         ev_ctrl_q <= `DCC_BYTE_ZERO;
         ien_q <= `DCC_BYTE_ZERO;
         iflags_q <= `DCC_BYTE_ZERO;
         active_q <= 1'b0;
         conv_lo_q <= `DCC_BYTE_ZERO;
         stage_lo_q <= `DCC_BYTE_ZERO;
      end
      else if (do_soft_reset_bit)
      begin
         // soft reset lands once the crossing is done, with the pin-reset values
         // kept as a plain synchronous branch so the async reset stays a pure pin reset
         ctrl_a_q <= `DCC_BYTE_ZERO;
         ctrl_b_q <= `DCC_BYTE_ZERO;
         ev_ctrl_q <= `DCC_BYTE_ZERO;
         ien_q <= `DCC_BYTE_ZERO;
         iflags_q <= `DCC_BYTE_ZERO;
         active_q <= 1'b0; // [RULE2]
         conv_lo_q <= `DCC_BYTE_ZERO;
         stage_lo_q <= `DCC_BYTE_ZERO;
      end
      else
      begin
         if (req_take && req_soft_reset_bit)
            ctrl_a_q[`DCC_A_SOFT_RESET_BIT] <= 1'b1; // [RULE3]
         else if (req_take && req_enable)
            ctrl_a_q <= reg_req.wdata & 8'h06; // [RULE1]
         if (do_enable)
            active_q <= ctrl_a_q[`DCC_A_ENABLE]; // [RULE1]
         if (wr_b && !ctrl_a_q[`DCC_A_ENABLE])
            ctrl_b_q <= reg_req.wdata & 8'hCF;
         if (wr_ev && !ctrl_a_q[`DCC_A_ENABLE])
            ev_ctrl_q <= reg_req.wdata & 8'({NUM_EV{1'b1}} << `DCC_EV_INV | 3);
         ien_q <= ien_d;
         iflags_q <= flags_d;
         if (wr_conv_lo)
            conv_lo_q <= reg_req.wdata;
         if (wr_stage_lo)
            stage_lo_q <= reg_req.wdata;
      end
   end

   // ==================================================
   // two-entry pipeline: staging then conversion value
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         conv_code_q <= `DCC_CODE_ZERO;
         stage_code_q <= `DCC_CODE_ZERO;
         stage_full_q <= 1'b0;
         conv_start_q <= 1'b0;
      end
      else if (do_soft_reset_bit)
      begin
         // soft reset empties both stages; a start arriving in that cycle is lost
         conv_code_q <= `DCC_CODE_ZERO;
         stage_code_q <= `DCC_CODE_ZERO;
         stage_full_q <= 1'b0; // [RULE2]
         conv_start_q <= 1'b0;
      end
      else
      begin
         conv_start_q <= (do_conv || move_stage) && active_q; // [RULE8]
         if (move_stage)
            conv_code_q <= stage_code_q; // [RULE9]
         else if (do_conv)
            conv_code_q <= dcc_unfmt(left, op_word_q);
         if (do_stage)
         begin
            stage_code_q <= dcc_unfmt(left, op_word_q);
            stage_full_q <= 1'b1;
         end
         else if (move_stage)
            stage_full_q <= 1'b0; // [RULE22]
      end
   end

   // ==================================================
   // registered outputs
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reg_rdata_q <= `DCC_BYTE_ZERO;
         irq_q <= 1'b0;
         empty_event_q <= 1'b0;
         analog_q <= '0;
      end
      else
      begin
         if (reg_req.rd)
            reg_rdata_q <= rd_mux;
         irq_q <= |(iflags_q & ien_q) && !do_soft_reset_bit; // [RULE12] [RULE13]
         empty_event_q <= went_empty && ev_ctrl_q[`DCC_EV_EMPTY_EVENT_OUT_ENABLE]; // [RULE23]
         analog_q <= analog_d;
      end
   end
endmodule : dcc_controller

/* File: tb/dcc_far_end.sv */
// far-side model: event network and dma engine feeding the controller
`timescale 1ns/1ps
module dcc_far_end (
   input logic ref_clk,
   input logic ev_cmd,
   input logic dma_cmd,
   input logic [15:0] dma_word,
   output logic start_ev,
   output logic dma_valid,
   output logic [15:0] dma_data
);
   // ==================================================
   // idle state before the first clock
   initial
   begin
      start_ev = 1'b0;
      dma_valid = 1'b0;
      dma_data = 16'h0000;
   end

   // launch off the falling edge; the event and dma valid both follow their command levels, one beat per cycle held
   always @(negedge ref_clk)
   begin
      start_ev <= ev_cmd;
      dma_valid <= dma_cmd; // beat spacing is decided by the bench
      dma_data <= dma_cmd ? dma_word : ~dma_data; // idle bus toggles so stale data never matches
   end
endmodule : dcc_far_end

/* File: tb/dcc_controller_monitor.sv */
// port-level assertion checker for the conversion controller
`timescale 1ns/1ps
module dcc_controller_monitor #(
   parameter int NUM_EV = 1,
   parameter int SYNC_CYCLES = 3
) (
   input logic ref_clk,
   input logic reset_n,
   input dcc_pkg::dcc_reg_req_t reg_req,
   input logic [7:0] reg_rdata_q,
   input logic dma_valid,
   input logic [15:0] dma_data,
   input logic [NUM_EV-1:0] start_ev,
   input logic standby,
   input logic supply_low,
   input logic [9:0] conv_code_q,
   input logic conv_start_q,
   input logic empty_event_q,
   input logic irq_q,
   input logic sync_error_q,
   input dcc_pkg::dcc_analog_t analog_q
);
   import dcc_pkg::*;
   // a load lands one crossing plus one cycle after it is taken
   localparam int LAT = SYNC_CYCLES + 1;
   localparam int SR_MAX = SYNC_CYCLES + 3;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // ==================================================
   // assertions
   a_start_cause:
      assert property (conv_start_q |-> $past(dma_valid, LAT)
         || ($past(reg_req.wr, LAT) && $past(reg_req.addr, LAT) == 4'h9)
         || $past(start_ev, 3) != $past(start_ev, 4))
      else $error("conversion start without a load");
   a_start_pulse:
      assert property (conv_start_q |=> !conv_start_q) else $error("start pulse too long");
   a_err_cause:
      assert property (sync_error_q |-> $past(dma_valid) || $past(reg_req.wr))
      else $error("sync error without a request");
   a_dma_refused:
      assert property (dma_valid ##1 dma_valid |=> sync_error_q)
      else $error("load during busy not refused");
   a_ref_legal:
      assert property (analog_q.ref_sel != 2'h3 && (!analog_q.ref_bad || analog_q.ref_sel == 2'h0))
      else $error("reference code out of range");
   a_pump_low:
      assert property (analog_q.pump_on |-> $past(supply_low)) else $error("pump on at high supply");
   a_empty_cause:
      assert property (empty_event_q |-> $past(start_ev, 3) != $past(start_ev, 4))
      else $error("empty event without start");
   a_soft_reset_bit_clears:
      assert property (reg_req.wr && reg_req.addr == 4'h0 && reg_req.wdata[0]
         |-> ##[1:SR_MAX] (!irq_q && !analog_q.ext_drive)) else $error("soft reset left outputs");
   c_start: cover property (conv_start_q);
   c_error: cover property (sync_error_q);
   c_empty: cover property (empty_event_q);
endmodule : dcc_controller_monitor

bind dcc_controller dcc_controller_monitor #(.NUM_EV(NUM_EV), .SYNC_CYCLES(SYNC_CYCLES)) mon (
   .ref_clk, .reset_n, .reg_req, .reg_rdata_q, .dma_valid, .dma_data, .start_ev, .standby,
   .supply_low, .conv_code_q, .conv_start_q, .empty_event_q, .irq_q, .sync_error_q, .analog_q);

/* File: tb/dcc_controller_bench.sv */
// self-checking bench for the conversion controller
`timescale 1ns/1ps
module dcc_controller_bench;
   import dcc_pkg::*;
   logic ref_clk, reset_n, dma_cmd, ev_cmd, standby, supply_low, dma_valid, start_ev;
   logic conv_start_q, empty_event_q, irq_q, sync_error_q;
   logic [15:0] dma_word, dma_data;
   logic [7:0] reg_rdata_q;
   logic [9:0] conv_code_q;
   dcc_reg_req_t reg_req;
   dcc_analog_t analog_q;
   int n_errors = 0;
   int checks_done = 0;
   int n_start = 0;
   int n_empty = 0;
   int n_err = 0;

   dcc_controller #(.NUM_EV(1), .SYNC_CYCLES(3)) uut (.ref_clk, .reset_n, .reg_req, .reg_rdata_q,
      .dma_valid, .dma_data, .start_ev, .standby, .supply_low, .conv_code_q, .conv_start_q,
      .empty_event_q, .irq_q, .sync_error_q, .analog_q);
   dcc_far_end far (.ref_clk, .ev_cmd, .dma_cmd, .dma_word, .start_ev, .dma_valid, .dma_data);

   // ==================================================
   // clock and pulse counters
   initial
   begin
      ref_clk = 1'b0;
      // the converter side shares this clock, well above four times the sample rate
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      n_start <= n_start + conv_start_q;
      n_empty <= n_empty + empty_event_q;
      n_err <= n_err + sync_error_q;
   end

   // ==================================================
   // shared tasks
   // the one compare of the bench: counts it, reports both values on a miss
   `define DCC_CHK(got, exp) \
      begin \
         checks_done++; \
         if ((got) !== (exp)) \
         begin \
            n_errors++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
         end \
      end
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      tick(1);
      reg_req <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
      tick(1);
      reg_req <= '0;
   endtask : wr
   // data is sampled a full cycle after the strobe, where it holds either way
   task automatic rd(input logic [3:0] a);
      tick(1);
      reg_req <= '{wr:1'b0, rd:1'b1, addr:a, wdata:8'h00};
      tick(1);
      reg_req <= '0;
      tick(1);
   endtask : rd
   task automatic dma(input logic [15:0] w, input int n);
      dma_word <= w;
      dma_cmd <= 1'b1;
      tick(n);
      dma_cmd <= 1'b0;
   endtask : dma
   task automatic settle(input int target);
      int k;
      k = 0;
      while (n_start < target && k < 16)
      begin
         tick(1);
         k++;
      end
      if (n_start < target)
      begin
         n_errors++;
         wrap_up;
      end
      tick(2);
   endtask : settle
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   // ==================================================
   // scenarios
   task automatic t_regs;
      logic [1:0] rs;
      for (int i = 0; i < 8; i++)
      begin
         rd(i[3:0]);
         `DCC_CHK(reg_rdata_q, 8'h00);
      end
      `DCC_CHK(analog_q, 6'h00);
      wr(4'h2, 8'h03);
      // every reference code, pump on and off, both outputs routed
      for (int i = 0; i < 4; i++)
      begin
         wr(4'h0, 8'h00);
         tick(5);
         wr(4'h1, {i[1:0], 2'b00, i[0], 3'b111});
         wr(4'h0, 8'h02);
         rd(4'h7);
         `DCC_CHK(reg_rdata_q[7], 1'b1);
         tick(5);
         rd(4'h7);
         `DCC_CHK(reg_rdata_q[7], 1'b0);
         rs = (i == 3) ? 2'h0 : i[1:0];
         `DCC_CHK(analog_q, {2'b11, !i[0], rs, i == 3});
         // at high supply the pump stays off whatever the disable bit says
         supply_low <= 1'b0;
         tick(3);
         `DCC_CHK(analog_q.pump_on, 1'b0);
         supply_low <= 1'b1;
      end
      wr(4'h1, 8'h00);
      rd(4'h1);
      `DCC_CHK(reg_rdata_q, 8'hCF);
      $display("test regs done");
   endtask : t_regs
   task automatic t_data;
      int s;
      s = n_start;
      wr(4'h8, 8'h40);
      wr(4'h9, 8'hD5);
      settle(s + 1);
      `DCC_CHK(conv_code_q, 10'h355);
      dma(16'h5540, 2);
      settle(s + 2);
      `DCC_CHK(conv_code_q, 10'h155);
      `DCC_CHK(n_err, 1);
      $display("test data done");
   endtask : t_data
   task automatic t_event;
      int s;
      s = n_start;
      wr(4'hC, 8'h00);
      wr(4'hD, 8'h80);
      tick(5);
      ev_cmd <= 1'b1;
      settle(s + 1);
      `DCC_CHK(conv_code_q, 10'h200);
      `DCC_CHK(n_empty, 1);
      rd(4'h6);
      `DCC_CHK(reg_rdata_q[1:0], 2'b10);
      for (int i = 0; i < 4; i++)
      begin
         wr((i == 1) ? 4'h4 : (i == 3) ? 4'h6 : 4'h5, 8'h02);
         tick(2);
         `DCC_CHK(irq_q, !i[0]);
      end
      // falling edge is ignored by default, the next rise finds the stage empty
      ev_cmd <= 1'b0;
      tick(6);
      ev_cmd <= 1'b1;
      tick(12);
      `DCC_CHK(n_start, s + 1);
      `DCC_CHK(conv_code_q, 10'h200);
      rd(4'h6);
      `DCC_CHK(reg_rdata_q[1:0], 2'b01);
      wr(4'h5, 8'h01);
      tick(2);
      `DCC_CHK(irq_q, 1'b1);
      wr(4'h0, 8'h00);
      tick(5);
      wr(4'h2, 8'h13);
      wr(4'h0, 8'h02);
      wr(4'hC, 8'h00);
      wr(4'hD, 8'h40);
      tick(5);
      ev_cmd <= 1'b0;
      settle(s + 2);
      `DCC_CHK(conv_code_q, 10'h100);
      $display("test event done");
   endtask : t_event
   task automatic t_power;
      standby <= 1'b1;
      tick(3);
      `DCC_CHK(analog_q.ext_drive, 1'b0);
      wr(4'h0, 8'h06);
      tick(5);
      `DCC_CHK(analog_q.ext_drive, 1'b1);
      standby <= 1'b0;
      wr(4'h0, 8'h03);
      rd(4'h0);
      // enable and standby bits written with the reset are dropped, the old ones stay
      `DCC_CHK(reg_rdata_q, 8'h07);
      tick(5);
      for (int i = 0; i < 6; i++)
      begin
         rd(i[3:0]);
         `DCC_CHK(reg_rdata_q[6:0], 7'h00);
      end
      `DCC_CHK({irq_q, analog_q.ext_drive, analog_q.int_route}, 3'b000);
      $display("test power done");
   endtask : t_power

   // ==================================================
   // main sequence
   initial
   begin
      reg_req = '0;
      dma_cmd = 1'b0;
      dma_word = 16'h0000;
      ev_cmd = 1'b0;
      standby = 1'b0;
      supply_low = 1'b1;
      reset_n = 1'b0;
      tick(2);
      reset_n <= 1'b1;
      t_regs;
      t_data;
      t_event;
      t_power;
      wrap_up;
   end
endmodule : dcc_controller_bench
